//--- logic/adc_channel_map_registers.sv
`timescale 1ns/100ps
//Contract
//- Bits 4:0 pick negative input code
//- Negative selector resets to input one
//- Second map at 0x12, reset 0x0001
//- Bit 15 enables channel two
//- Several enabled channels sequence automatically
//- Bits 13:12 choose setup, reset zero
//- Setup bundles four registers applied together
//- Bits 9:5 pick positive input code
module adc_channel_map_registers (
   input  wire logic        clk_sys,          // System clock, 40 MHz.
   input  wire logic        reset_n,          // Synchronous reset, active low.
   input  wire logic        clkEn,            // Clock enable; all state holds while low.
   input  wire logic        psel,             // APB select.
   input  wire logic        penable,          // APB enable.
   input  wire logic        pwrite,           // APB direction, high for write.
   input  wire logic [11:0] paddr,            // APB byte address.
   input  wire logic [31:0] pwdata,           // APB write data.
   output logic      [31:0] prdata,           // APB read data.
   output logic             pready,           // APB ready.
   output logic             pslverr,          // APB error for unmapped address.
   input  wire logic        convDone,         // Pulse from converter: conversion finished.
   output logic      [1:0]  chanEnable,       // Enable bits of both channels.
   output logic             activeChannel,    // Channel now connected to the modulator.
   output logic      [4:0]  activePosSelect,  // Positive input code for active channel.
   output logic      [4:0]  activeNegSelect,  // Negative input code for active channel.
   output logic      [1:0]  activeSetup,      // Setup index applied to active channel.
   output logic             autoSequence,     // High when more than one channel is enabled.
   output logic             conversionRun     // High while any channel is enabled.
);

   logic [15:0] chanMap [adc_chmap_pkg::NUM_CH];
   logic [1:0]  mapHit;
   logic        statusHit;
   logic        addrOk;
   logic        setupPhase;
   logic        writeStrobe;
   logic        curChan;
   logic        seqRunning;
   logic        codeError;
   logic [15:0] statusWord;
   logic [15:0] next_readWord;
   logic [9:0]  regIndex;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.
   assign regIndex    = paddr[11:2];
   assign mapHit[0]   = (regIndex == adc_chmap_pkg::IDX_CHANNEL_MAP_ONE);
   assign mapHit[1]   = (regIndex == adc_chmap_pkg::IDX_CHANNEL_MAP_TWO);
   assign statusHit   = (regIndex == adc_chmap_pkg::IDX_SEQ_STATUS);
   assign addrOk      = (mapHit != 2'h0) || statusHit;
   assign setupPhase  = psel && !penable;
   assign writeStrobe = psel && penable && pwrite && clkEn;

   // Read data is latched in the setup phase, so every access with clkEn high completes in one access cycle.
   assign pready  = psel && penable && clkEn;
   assign pslverr = psel && penable && clkEn && !addrOk;

   ////////////////////////////////////////////////////////////////////////////
   // Channel map registers. Reserved bits never take write data, so a host that
   // ignores its duty to write zeros there still reads zeros back.
   generate
      for (genvar ch = 0; ch < adc_chmap_pkg::NUM_CH; ch++) begin : gMap
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               chanMap[ch] <= (ch == 0) ? adc_chmap_pkg::RST_CHANNEL_MAP_ONE
                                        : adc_chmap_pkg::RST_CHANNEL_MAP_TWO;
            end else if (writeStrobe && mapHit[ch]) begin
               chanMap[ch] <= pwdata[15:0] & adc_chmap_pkg::WRITE_MASK;
            end
         end
         assign chanEnable[ch] = chanMap[ch][adc_chmap_pkg::EN_BIT];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing across enabled channels.
   chan_sequencer uSeq (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .enMask   (chanEnable),
      .convDone (convDone),
      .curChan  (curChan),
      .running  (seqRunning)
   );

   // Flags an enabled channel whose selector holds a code outside the legal set.
   always_comb begin
      codeError = 1'b0;
      for (int i = 0; i < adc_chmap_pkg::NUM_CH; i++) begin
         if (chanEnable[i] &&
             (!adc_chmap_pkg::codeLegal(chanMap[i][adc_chmap_pkg::POS_HI:adc_chmap_pkg::POS_LO]) ||
              !adc_chmap_pkg::codeLegal(chanMap[i][adc_chmap_pkg::NEG_HI:adc_chmap_pkg::NEG_LO]))) begin
            codeError = 1'b1;
         end
      end
   end

   always_comb begin
      statusWord                              = 16'h0000;
      statusWord[adc_chmap_pkg::ST_CUR_CH]    = curChan;
      statusWord[adc_chmap_pkg::ST_AUTO_SEQ]  = &chanEnable;
      statusWord[adc_chmap_pkg::ST_RUN]       = seqRunning;
      statusWord[adc_chmap_pkg::ST_CODE_ERR]  = codeError;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path.
   always_comb begin
      if (mapHit[0]) begin
         next_readWord = chanMap[0];
      end else if (mapHit[1]) begin
         next_readWord = chanMap[1];
      end else if (statusHit) begin
         next_readWord = statusWord;
      end else begin
         next_readWord = 16'h0000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (clkEn && setupPhase) begin
         prdata <= {16'h0000, next_readWord};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs toward the modulator front end, registered. The setup index is
   // handed on whole: configuration, filter, offset and gain follow it together.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         activeChannel   <= 1'b0;
         activePosSelect <= adc_chmap_pkg::RST_CHANNEL_MAP_ONE[adc_chmap_pkg::POS_HI:adc_chmap_pkg::POS_LO];
         activeNegSelect <= adc_chmap_pkg::RST_CHANNEL_MAP_ONE[adc_chmap_pkg::NEG_HI:adc_chmap_pkg::NEG_LO];
         activeSetup     <= 2'h0;
         autoSequence    <= 1'b0;
         conversionRun   <= 1'b0;
      end else if (clkEn) begin
         activeChannel   <= curChan;
         activePosSelect <= chanMap[curChan][adc_chmap_pkg::POS_HI:adc_chmap_pkg::POS_LO];
         activeNegSelect <= chanMap[curChan][adc_chmap_pkg::NEG_HI:adc_chmap_pkg::NEG_LO];
         activeSetup     <= chanMap[curChan][adc_chmap_pkg::SETUP_HI:adc_chmap_pkg::SETUP_LO];
         autoSequence    <= &chanEnable;
         conversionRun   <= seqRunning;
      end
   end

endmodule

//--- logic/adc_chmap_pkg.sv
package adc_chmap_pkg;

   localparam int unsigned NUM_CH = 2;
   localparam int unsigned REG_W  = 16;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0] IDX_CHANNEL_MAP_ONE = 10'h010;
   localparam logic [9:0] IDX_CHANNEL_MAP_TWO = 10'h012;
   localparam logic [9:0] IDX_SEQ_STATUS      = 10'h013;

   // Field layout shared by both channel map registers.
   localparam int unsigned EN_BIT   = 15;
   localparam int unsigned RSV_BIT  = 14;
   localparam int unsigned SETUP_HI = 13;
   localparam int unsigned SETUP_LO = 12;
   localparam int unsigned RSV2_HI  = 11;
   localparam int unsigned RSV2_LO  = 10;
   localparam int unsigned POS_HI   = 9;
   localparam int unsigned POS_LO   = 5;
   localparam int unsigned NEG_HI   = 4;
   localparam int unsigned NEG_LO   = 0;

   localparam logic [15:0] RST_CHANNEL_MAP_ONE = 16'h0001;
   localparam logic [15:0] RST_CHANNEL_MAP_TWO = 16'h0001;
   // Writable bits: enable, setup choice, positive and negative selectors.
   localparam logic [15:0] WRITE_MASK          = 16'hb3ff;

   // Input selector codes.
   localparam logic [4:0] CODE_AIN_FIRST = 5'h00;
   localparam logic [4:0] CODE_AIN_LAST  = 5'h04;
   localparam logic [4:0] CODE_REF_POS   = 5'h15;
   localparam logic [4:0] CODE_REF_NEG   = 5'h16;

   // Status register bit positions.
   localparam int unsigned ST_CUR_CH   = 0;
   localparam int unsigned ST_AUTO_SEQ = 1;
   localparam int unsigned ST_RUN      = 2;
   localparam int unsigned ST_CODE_ERR = 3;

   typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

   function automatic logic codeLegal(input logic [4:0] code);
      codeLegal = (code <= CODE_AIN_LAST) || (code == CODE_REF_POS) || (code == CODE_REF_NEG);
   endfunction

endpackage

//--- logic/chan_sequencer.sv
`timescale 1ns/100ps
module chan_sequencer (
   input  wire logic        clk_sys,    // System clock.
   input  wire logic        reset_n,    // Synchronous reset, active low.
   input  wire logic        clkEn,      // Clock enable; state holds while low.
   input  wire logic [1:0]  enMask,     // Channel enable bits, one per channel.
   input  wire logic        convDone,   // Pulse: conversion on current channel finished.
   output logic             curChan,    // Channel currently being converted.
   output logic             running     // At least one channel enabled.
);

   adc_chmap_pkg::seq_state_t state;
   logic                      nextChan;

   ////////////////////////////////////////////////////////////////////////////
   // Next enabled channel after the current one; wraps so a lone channel stays.
   always_comb begin
      if (enMask[~curChan]) begin
         nextChan = ~curChan;
      end else begin
         nextChan = curChan;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state   <= adc_chmap_pkg::SEQ_IDLE;
         curChan <= 1'b0;
         running <= 1'b0;
      end else if (clkEn) begin
         unique case (state)
            adc_chmap_pkg::SEQ_IDLE: begin
               if (enMask != 2'h0) begin
                  state   <= adc_chmap_pkg::SEQ_RUN;
                  curChan <= enMask[0] ? 1'b0 : 1'b1;
                  running <= 1'b1;
               end
            end
            adc_chmap_pkg::SEQ_RUN: begin
               if (enMask == 2'h0) begin
                  state   <= adc_chmap_pkg::SEQ_IDLE;
                  running <= 1'b0;
               end else if (!enMask[curChan] || convDone) begin
                  // A disabled channel is left at once rather than finishing its conversion.
                  curChan <= nextChan;
               end
            end
         endcase
      end
   end

endmodule

//--- verif/adc_channel_map_registers_assertions.sv
`timescale 1ns/100ps
module adc_channel_map_registers_checker (
   input wire logic        clk_sys,       // Clock.
   input wire logic        reset_n,       // Reset.
   input wire logic        clkEn,         // Enable.
   input wire logic        psel,          // Select.
   input wire logic        penable,       // Access.
   input wire logic        pwrite,        // Direction.
   input wire logic [11:0] paddr,         // Address.
   input wire logic [31:0] pwdata,        // Write data.
   input wire logic [31:0] prdata,        // Read data.
   input wire logic        pready,        // Ready.
   input wire logic        pslverr,       // Error.
   input wire logic        convDone,      // Done pulse.
   input wire logic [1:0]  chanEnable,    // Enables.
   input wire logic        activeChannel, // Channel.
   input wire logic        autoSequence,  // Both on.
   input wire logic        conversionRun  // Running.
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic acc;
   logic mapped;
   assign acc = psel && penable && clkEn;
   assign mapped = paddr[11:2] inside {adc_chmap_pkg::IDX_CHANNEL_MAP_ONE, adc_chmap_pkg::IDX_CHANNEL_MAP_TWO,
                                       adc_chmap_pkg::IDX_SEQ_STATUS};
   ready_zero_wait_a: assert property (acc |-> pready) else $error("pready missing");
   ready_idle_a: assert property (!acc |-> !pready) else $error("pready outside access");
   unmapped_error_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("prdata upper set");
   enable_write_a: assert property (acc && pwrite && paddr[11:2] == adc_chmap_pkg::IDX_CHANNEL_MAP_TWO
      |=> chanEnable[1] == $past(pwdata[15])) else $error("enable bit not written");
   auto_both_a: assert property ((clkEn && chanEnable == 2'b11) [*3] |-> autoSequence) else $error("no auto");
   auto_single_a: assert property ((clkEn && chanEnable != 2'b11) [*3] |-> !autoSequence) else $error("auto");
   run_idle_a: assert property ((clkEn && chanEnable == 2'b00) [*3] |-> !conversionRun) else $error("run");
   only_second_a: assert property ((clkEn && chanEnable == 2'b10) [*3] |-> activeChannel) else $error("chan");
   // Both enables must stand at the pulse itself: the registered auto flag lags a disabling write by one cycle.
   seq_advance_a: assert property (clkEn && convDone && autoSequence && chanEnable == 2'b11 ##1 clkEn
      |=> activeChannel != $past(activeChannel)) else $error("sequence did not advance");
endmodule

bind adc_channel_map_registers adc_channel_map_registers_checker u_chk (.clk_sys, .reset_n, .clkEn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .convDone, .chanEnable, .activeChannel, .autoSequence,
   .conversionRun);

//--- verif/adc_channel_map_registers_test.sv
`timescale 1ns/100ps
module adc_channel_map_registers_test;
   localparam logic [11:0] A_ONE = {adc_chmap_pkg::IDX_CHANNEL_MAP_ONE, 2'b00};
   localparam logic [11:0] A_TWO = {adc_chmap_pkg::IDX_CHANNEL_MAP_TWO, 2'b00};
   localparam logic [11:0] A_STAT = {adc_chmap_pkg::IDX_SEQ_STATUS, 2'b00};
   logic        clk_sys, reset_n, clkEn, convDone, psel, penable, pwrite, pready, pslverr, actCh, autoSeq, run, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0]  chEn, actSetup;
   logic [4:0]  actPos, actNeg;
   int          n_errors, n_checks;
   adc_channel_map_registers u_adc_channel_map_registers (.clk_sys, .reset_n, .clkEn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .convDone, .chanEnable(chEn), .activeChannel(actCh),
      .activePosSelect(actPos), .activeNegSelect(actNeg), .activeSetup(actSetup), .autoSequence(autoSeq),
      .conversionRun(run));
   apb_host_model u_apb_host_model (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_apb_host_model.xfer(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a);
      u_apb_host_model.xfer(1'b0, a, 32'h00000000, r, e);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(A_TWO);
      chk("map two reset", 32'h00000001, r);
      rd(A_ONE);
      chk("map one reset", 32'h00000001, r);
      chk("neg select reset", 32'h00000001, {27'h0, actNeg});
      rd(12'h0fc);
      chk("unmapped", 32'h00000001, {r[30:0], e});
      $display("test reset done");
   endtask
   // Channel one is off, so channel two alone drives the active outputs.
   task automatic t_codes;
      logic [4:0]  codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h15, 5'h16};
      logic [15:0] v;
      wr(A_ONE, 32'h00000000);
      for (int i = 0; i < 7; i++) begin
         v = {1'b1, 1'b0, 2'(i), 2'b00, codes[i], codes[6 - i]};
         wr(A_TWO, {16'h0000, v});
         rd(A_TWO);
         chk("map two", {16'h0000, v}, r);
         repeat (4) @(posedge clk_sys);
         chk("active", {19'h0, 1'b1, codes[i], codes[6 - i], 2'(i)},
             {19'h0, actCh, actPos, actNeg, actSetup});
      end
      // An illegal positive code is stored as written and raised in the status word.
      wr(A_TWO, 32'h000083e1);
      rd(A_STAT);
      chk("status code error", 32'h0000000d, r);
      $display("test codes done");
   endtask
   task automatic t_seq;
      logic [1:0] expSetup;
      wr(A_ONE, 32'h00009043);
      wr(A_TWO, 32'h0000a095);
      repeat (4) @(posedge clk_sys);
      chk("auto run", 32'h00000003, {30'h0, autoSeq, run});
      rd(A_STAT);
      chk("status both", 32'h00000007, r);
      // Channel two is active on entry; the last two steps point both channels at one shared setup.
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            wr(A_ONE, 32'h0000b043);
            wr(A_TWO, 32'h0000b095);
         end
         expSetup = (k >= 2) ? 2'b11 : (k == 1) ? 2'b10 : 2'b01;
         convDone <= 1'b1;
         @(posedge clk_sys);
         convDone <= 1'b0;
         repeat (4) @(posedge clk_sys);
         chk("next channel", {29'h0, 1'(k), expSetup}, {29'h0, actCh, actSetup});
      end
      wr(A_ONE, 32'h00000000);
      wr(A_TWO, 32'h00000000);
      repeat (4) @(posedge clk_sys);
      chk("stopped", 32'h00000000, {29'h0, chEn, run});
      $display("test sequence done");
   endtask
   // Clock enable low must swallow a conversion-done pulse and leave the sequence where it was.
   task automatic t_hold;
      wr(A_ONE, 32'h00009043);
      wr(A_TWO, 32'h0000a095);
      repeat (4) @(posedge clk_sys);
      clkEn <= 1'b0;
      convDone <= 1'b1;
      @(posedge clk_sys);
      convDone <= 1'b0;
      repeat (4) @(posedge clk_sys);
      clkEn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("frozen channel", 32'h00000000, {31'h0, actCh});
      $display("test hold done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_errors++;
      wrap_up();
   end
   initial begin
      reset_n = 1'b0;
      clkEn = 1'b1;
      convDone = 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset();
      t_codes();
      t_seq();
      t_hold();
      wrap_up();
   end
endmodule

//--- verif/apb_host_model.sv
`timescale 1ns/100ps
module apb_host_model (
   input wire logic        clk_sys, // Clock.
   output logic            psel,    // Select.
   output logic            penable, // Access.
   output logic            pwrite,  // Direction.
   output logic [11:0]     paddr,   // Address.
   output logic [31:0]     pwdata,  // Write data.
   input wire logic [31:0] prdata,  // Read data.
   input wire logic        pready,  // Ready.
   input wire logic        pslverr  // Error.
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // Waits one edge first so back-to-back calls never drive a signal twice in one step.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d & 32'h0000b3ff;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata;
   endtask
endmodule
